/* File: tkd_cfg.svh */
`ifndef TKD_CFG_SVH
`define TKD_CFG_SVH

// ----------------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------------
`define TKD_KEYPAD_PAGE    8'hC0
`define TKD_DISPLAY_PAGE   8'hC1
`define TKD_PAGE_HI        15
`define TKD_PAGE_LO        8
`define TKD_DIG_HI         6
`define TKD_DIG_LO         4
`define TKD_SEG_HI         2
`define TKD_SEG_LO         0
`define TKD_DIG_FIRST      4'h1
`define TKD_DEC_HIGH_IN    1'b0
`define TKD_SEG_DATA_BIT   0
`define TKD_COL_NONE       3'h7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TKD_SEG_RESET      8'hFF
`define TKD_DATA_IDLE      8'hFF
`define TKD_ROW_PAD        2'h3
`define TKD_COL_RESET      3'h7
`define TKD_ADDR_RESET     16'hFFFF

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define TKD_CLK_PERIOD_NS  4
`define TKD_PHI_PERIOD_NS  2000
`define TKD_PHI_GAP_NS     20
`define TKD_RST_PULSE_NS   20000
`define TKD_PHI_PERIOD_CYC (`TKD_PHI_PERIOD_NS / `TKD_CLK_PERIOD_NS)
`define TKD_PHI_HALF_CYC   (`TKD_PHI_PERIOD_CYC / 2)
`define TKD_PHI_GAP_CYC    ((`TKD_PHI_GAP_NS + `TKD_CLK_PERIOD_NS - 1) / `TKD_CLK_PERIOD_NS)
`define TKD_RST_PULSE_CYC  ((`TKD_RST_PULSE_NS + `TKD_CLK_PERIOD_NS - 1) / `TKD_CLK_PERIOD_NS)

`endif

/* File: tkd_pkg.sv */
package tkd_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic        valid_mem_addr;
    logic        ba;
  } tkd_cpu_bus_t;

  typedef logic [5:0][2:0] tkd_keymat_t;

  typedef logic [5:0][7:0] tkd_seg_bank_t;

  typedef enum logic [1:0] {
    RST_IDLE,
    RST_HOLD,
    RST_STRETCH
  } tkd_rst_state_t;

endpackage

/* File: tkd_seg_latch.sv */
`timescale 1ns/1ps
`default_nettype none

module tkd_seg_latch
  import tkd_pkg::*;
#(
  parameter int SEGS = 8
) (
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic            en_i,
  input  wire logic [2:0]      sel_i,
  input  wire logic            d_i,
  output logic      [SEGS-1:0] q_o
);

  `include "tkd_cfg.svh"

  initial begin
    if (SEGS < 1 || SEGS > 8) $error("SEGS must be 1..8");
  end

  logic [SEGS-1:0] q_r;
  logic [SEGS-1:0] q_nxt;

  // ---------------------------------------------------------------------------
  // addressable latch: bit picked by sel_i takes d_i on the clock edge while enabled, holds otherwise
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < SEGS; i++) begin : g_seg
    always_comb begin
      if (en_i && sel_i == 3'(i)) begin
        q_nxt[i] = d_i;
      end else begin
        q_nxt[i] = q_r[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= SEGS'(`TKD_SEG_RESET);
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

  a_latch_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !en_i |=> $stable(q_o))
    else $error("segment latch changed while not enabled");

endmodule

`default_nettype wire

/* File: tkd_glue.sv */
`timescale 1ns/1ps
`default_nettype none

module tkd_glue
  import tkd_pkg::*;
#(
  parameter int DIGITS        = 6,
  parameter int RST_PULSE_CYC = 5000
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire tkd_cpu_bus_t        cpu_bus_i,
  input  wire logic                three_state_request_i,
  input  wire logic                reset_key_n_i,
  input  wire logic                terminal_dir_reverse_n_i,
  input  wire tkd_keymat_t         keys_closed_i,
  input  wire logic [7:0]          data_i,
  output logic      [7:0]          data_o,
  output logic                     data_oe_o,
  output logic                     phi1_o,
  output logic                     phi2_o,
  output logic                     cpu_reset_n_o,
  output logic      [15:0]         addr_buf_o,
  output logic                     addr_oe_o,
  output logic                     rw_buf_o,
  output logic                     rw_oe_o,
  output logic                     data_bus_drive_en_o,
  output logic                     data_bus_drive_en_oe_o,
  output logic                     qualified_mem_strobe_n_o,
  output logic                     qualified_mem_strobe_n_oe_o,
  output logic      [2:0]          key_col_o,
  output logic                     terminal_drive_out_o,
  output logic [DIGITS-1:0][7:0]   seg_n_o
);

  `include "tkd_cfg.svh"

  localparam int PHI_PERIOD = `TKD_PHI_PERIOD_CYC;
  localparam int PHI_HALF   = `TKD_PHI_HALF_CYC;
  localparam int PHI_GAP    = `TKD_PHI_GAP_CYC;

  initial begin
    if (DIGITS < 1 || DIGITS > 7) $error("DIGITS must be 1..7");
    if (RST_PULSE_CYC < 2) $error("RST_PULSE_CYC must be at least 2");
    if (PHI_GAP >= PHI_HALF) $error("phase gap must be below half period");
  end

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  localparam int SW = $bits(tkd_cpu_bus_t) + 3 + $bits(tkd_keymat_t) + 1;

  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  tkd_cpu_bus_t  bus_s;
  tkd_keymat_t   keys_s;
  logic          tsc_s;
  logic          key_n_s;
  logic          rev_n_s;
  logic          d0_s;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= {cpu_bus_i, three_state_request_i, reset_key_n_i,
                  terminal_dir_reverse_n_i, keys_closed_i,
                  data_i[`TKD_SEG_DATA_BIT]};
      sync2_r <= sync1_r;
    end
  end

  assign {bus_s, tsc_s, key_n_s, rev_n_s, keys_s, d0_s} = sync2_r;

  // ---------------------------------------------------------------------------
  // two-phase clock generator
  // ---------------------------------------------------------------------------
  logic [$clog2(PHI_PERIOD)-1:0] phi_cnt_r;
  logic [$clog2(PHI_PERIOD)-1:0] phi_cnt_nxt;
  logic                          phi1_r;
  logic                          phi1_nxt;
  logic                          phi2_r;
  logic                          phi2_nxt;

  always_comb begin
    if (int'(phi_cnt_r) == PHI_PERIOD - 1) begin
      phi_cnt_nxt = '0;
    end else begin
      phi_cnt_nxt = phi_cnt_r + 1'b1;
    end
    // dead band at the start of each half keeps the phases apart
    phi1_nxt = int'(phi_cnt_nxt) >= PHI_GAP && int'(phi_cnt_nxt) < PHI_HALF;
    phi2_nxt = int'(phi_cnt_nxt) >= PHI_HALF + PHI_GAP;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phi_cnt_r <= '0;
      phi1_r    <= 1'b0;
      phi2_r    <= 1'b0;
    end else begin
      phi_cnt_r <= phi_cnt_nxt;
      phi1_r    <= phi1_nxt;
      phi2_r    <= phi2_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // reset pulse shaper
  // ---------------------------------------------------------------------------
  tkd_rst_state_t      rst_st_r;
  tkd_rst_state_t      rst_st_nxt;
  logic [31:0]         rst_cnt_r;
  logic [31:0]         rst_cnt_nxt;

  // pulse lasts at least RST_PULSE_CYC however short the key press is
  always_comb begin
    rst_st_nxt  = rst_st_r;
    rst_cnt_nxt = rst_cnt_r;
    case (rst_st_r)
      RST_IDLE: begin
        if (!key_n_s) begin
          rst_st_nxt = RST_HOLD;
        end
      end
      RST_HOLD: begin
        rst_cnt_nxt = 32'(RST_PULSE_CYC - 1);
        if (key_n_s) begin
          rst_st_nxt = RST_STRETCH;
        end
      end
      RST_STRETCH: begin
        if (!key_n_s) begin
          rst_st_nxt = RST_HOLD;
        end else if (rst_cnt_r == '0) begin
          rst_st_nxt = RST_IDLE;
        end else begin
          rst_cnt_nxt = rst_cnt_r - 1'b1;
        end
      end
      default: begin
        rst_st_nxt = RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_st_r  <= RST_HOLD;
      rst_cnt_r <= '0;
    end else begin
      rst_st_r  <= rst_st_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // bus buffers and qualified strobe
  // ---------------------------------------------------------------------------
  logic        float_nxt;
  logic        float_r;
  logic        strobe_n_nxt;
  logic        strobe_n_r;
  logic [15:0] addr_r;
  logic        rw_r;

  always_comb begin
    float_nxt    = tsc_s || bus_s.ba;
    strobe_n_nxt = !(bus_s.valid_mem_addr && phi2_r);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      float_r    <= 1'b1;
      strobe_n_r <= 1'b1;
      addr_r     <= `TKD_ADDR_RESET;
      rw_r       <= 1'b1;
    end else begin
      float_r    <= float_nxt;
      strobe_n_r <= strobe_n_nxt;
      addr_r     <= bus_s.addr;
      rw_r       <= bus_s.rw;
    end
  end

  // ---------------------------------------------------------------------------
  // keypad and display decode
  // ---------------------------------------------------------------------------
  logic [7:0]        page;
  logic              kp_sel;
  logic              disp_sel;
  logic [3:0]        dig_code;
  logic [2:0]        col;
  logic [5:0]        row_n;
  logic [DIGITS-1:0] dig_en;
  logic [7:0]        data_nxt;
  logic [7:0]        data_r;
  logic              data_oe_r;
  logic [2:0]        col_r;

  assign page     = addr_r[`TKD_PAGE_HI:`TKD_PAGE_LO];
  assign col      = addr_r[`TKD_SEG_HI:`TKD_SEG_LO];
  assign kp_sel   = page == `TKD_KEYPAD_PAGE && !strobe_n_r;
  assign disp_sel = page == `TKD_DISPLAY_PAGE && !strobe_n_r;
  assign dig_code = {`TKD_DEC_HIGH_IN, addr_r[`TKD_DIG_HI:`TKD_DIG_LO]};

  // row r, column c: key closes when column c line is low
  for (genvar r = 0; r < 6; r++) begin : g_row
    assign row_n[r] = !(|(keys_s[r] & ~col));
  end

  // digit index 0 is rightmost, reached by code 1
  for (genvar g = 0; g < DIGITS; g++) begin : g_dig
    assign dig_en[g] = disp_sel && dig_code == `TKD_DIG_FIRST + 4'(g);

    tkd_seg_latch #(
      .SEGS(8)
    ) u_latch (
      .clk_sys_i(clk_sys_i),
      .rst_i    (rst_i),
      .en_i     (dig_en[g]),
      .sel_i    (col),
      .d_i      (!d0_s),
      .q_o      (seg_n_o[g])
    );
  end

  always_comb begin
    if (kp_sel) begin
      data_nxt = {`TKD_ROW_PAD, row_n};
    end else begin
      data_nxt = `TKD_DATA_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_r    <= `TKD_DATA_IDLE;
      data_oe_r <= 1'b0;
      col_r     <= `TKD_COL_RESET;
    end else begin
      data_r    <= data_nxt;
      data_oe_r <= kp_sel;
      col_r     <= col;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign data_o                      = data_r;
  assign data_oe_o                   = data_oe_r;
  assign phi1_o                      = phi1_r;
  assign phi2_o                      = phi2_r;
  assign data_bus_drive_en_o         = phi2_r;
  assign cpu_reset_n_o               = rst_st_r == RST_IDLE;
  assign addr_buf_o                  = addr_r;
  assign rw_buf_o                    = rw_r;
  assign qualified_mem_strobe_n_o    = strobe_n_r;
  // pulls outside set the floated levels, so only enables drop here
  assign addr_oe_o                   = !float_r;
  assign rw_oe_o                     = !float_r;
  assign data_bus_drive_en_oe_o      = !float_r;
  assign qualified_mem_strobe_n_oe_o = !float_r;
  assign key_col_o                   = col_r;
  assign terminal_drive_out_o        = rev_n_s;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_key_tap;
    key_n_s ##1 !key_n_s ##1 key_n_s;
  endsequence

  a_keypad_enable: assert property (kp_sel |=> data_oe_o && data_o[7:6] == 2'h3)
    else $error("keypad buffer not enabled on keypad page");
  a_keypad_off: assert property (!kp_sel |=> !data_oe_o)
    else $error("keypad buffer enabled off page");
  a_column_drive: assert property (##1 key_col_o == $past(col))
    else $error("column lines do not follow low address bits");
  a_key_f_row: assert property (kp_sel && col == 3'h3 && keys_s[0][2] |=> !data_o[0])
    else $error("key F did not pull row 0 low");
  a_no_column: assert property (kp_sel && col == `TKD_COL_NONE |=> data_o == 8'hFF)
    else $error("data low with no column selected");
  a_seg_invert: assert property (dig_en[0] && col == 3'h0 |=> seg_n_o[0][0] == !$past(d0_s))
    else $error("segment latch did not take inverted data bit 0");
  a_left_digit: assert property (disp_sel && dig_code == 4'h6 |-> dig_en[DIGITS-1])
    else $error("code 6 did not pick leftmost digit");
  a_strobe_nand: assert property (##1 strobe_n_r == !($past(bus_s.valid_mem_addr) && $past(phi2_r)))
    else $error("qualified strobe not NAND of valid address and phase 2");
  a_float_ctl: assert property ((tsc_s || bus_s.ba) |=> !addr_oe_o && !rw_oe_o
    && !qualified_mem_strobe_n_oe_o && !data_bus_drive_en_oe_o)
    else $error("buffers still driven during three-state request");
  a_phase_apart: assert property (!(phi1_o && phi2_o) && data_bus_drive_en_o == phi2_o)
    else $error("phases overlap or bus enable not phase 2");
  a_reset_pulse: assert property (s_key_tap |-> !cpu_reset_n_o [*3])
    else $error("reset pulse too short after key press");

endmodule

`default_nettype wire

/* File: tkd_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tkd_cpu_model
  import tkd_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         phi2_i,
  input  wire logic         ba_i,
  input  wire logic [7:0]   rdata_i,
  input  wire logic         rdata_oe_i,
  output var  tkd_cpu_bus_t bus_o,
  output logic      [7:0]   wdata_o
);
  logic [15:0] addr_r;
  logic        rw_r;
  logic        vma_r;

  assign bus_o = '{addr: addr_r, rw: rw_r, valid_mem_addr: vma_r, ba: ba_i};

  initial begin
    addr_r  = 16'hFFFE;
    rw_r    = 1'b1;
    vma_r   = 1'b0;
    wdata_o = 8'h5A;
  end

  task automatic wait_phi(input logic lvl);
    int n;
    n = 0;
    while (phi2_i !== lvl && n < 1000) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask

  // ----------------------------------------------------------------------------
  // one memory cycle, started in phase 1 and closed after phase 2 ends
  // ----------------------------------------------------------------------------
  task automatic access(input logic [15:0] a, input logic rw, input logic v,
                        input logic [7:0] wd, output logic [7:0] rd, output logic oe);
    wait_phi(1'b0);
    addr_r  = a;
    rw_r    = rw;
    vma_r   = v;
    // undriven data lines never keep the old value
    wdata_o = rw ? ~wdata_o : wd;
    wait_phi(1'b1);
    repeat (12) @(negedge clk_sys_i);
    rd = rdata_oe_i ? rdata_i : ~wdata_o;
    oe = rdata_oe_i;
    wait_phi(1'b0);
    vma_r   = 1'b0;
    wdata_o = ~wdata_o;
  endtask
endmodule

`default_nettype wire

/* File: trainer_keypad_display_glue_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module trainer_keypad_display_glue_tb
  import tkd_pkg::*;
;
  logic          clk_sys_i = 1'b0;
  logic          rst_i;
  logic          tsr;
  logic          key_n;
  logic          rev_n;
  logic          ba;
  tkd_keymat_t   keys;
  tkd_cpu_bus_t  bus;
  logic [7:0]    wdata;
  logic [7:0]    dout;
  logic          d_oe;
  logic          phi1;
  logic          phi2;
  logic          cpu_rst_n;
  logic [15:0]   a_buf;
  logic          a_oe;
  logic          rw_b;
  logic          rw_oe;
  logic          dbe;
  logic          dbe_oe;
  logic          strb;
  logic          strb_oe;
  logic [2:0]    col;
  logic          tdo;
  tkd_seg_bank_t seg;
  tkd_seg_bank_t exp_seg;
  logic [31:0]   seed = 32'h9597;
  logic [31:0]   r;
  int            comparisons;
  int            mismatches;

  // board pulls on the floated control lines
  wire logic dbe_w  = dbe_oe ? dbe : 1'b0;
  wire logic rw_w   = rw_oe ? rw_b : 1'b1;
  wire logic strb_w = strb_oe ? strb : 1'b1;

  always #2 clk_sys_i = ~clk_sys_i;

  tkd_glue #(.DIGITS(6), .RST_PULSE_CYC(8)) i_tkd_glue (
    .clk_sys_i                   (clk_sys_i),
    .rst_i                       (rst_i),
    .cpu_bus_i                   (bus),
    .three_state_request_i       (tsr),
    .reset_key_n_i               (key_n),
    .terminal_dir_reverse_n_i    (rev_n),
    .keys_closed_i               (keys),
    .data_i                      (wdata),
    .data_o                      (dout),
    .data_oe_o                   (d_oe),
    .phi1_o                      (phi1),
    .phi2_o                      (phi2),
    .cpu_reset_n_o               (cpu_rst_n),
    .addr_buf_o                  (a_buf),
    .addr_oe_o                   (a_oe),
    .rw_buf_o                    (rw_b),
    .rw_oe_o                     (rw_oe),
    .data_bus_drive_en_o         (dbe),
    .data_bus_drive_en_oe_o      (dbe_oe),
    .qualified_mem_strobe_n_o    (strb),
    .qualified_mem_strobe_n_oe_o (strb_oe),
    .key_col_o                   (col),
    .terminal_drive_out_o        (tdo),
    .seg_n_o                     (seg)
  );

  tkd_cpu_model i_tkd_cpu_model (
    .clk_sys_i  (clk_sys_i),
    .phi2_i     (phi2),
    .ba_i       (ba),
    .rdata_i    (dout),
    .rdata_oe_i (d_oe),
    .bus_o      (bus),
    .wdata_o    (wdata)
  );

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] kp_exp(input tkd_keymat_t k, input logic [2:0] c);
    logic [7:0] v;
    v = 8'hFF;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (k[i][j] && !c[j]) v[i] = 1'b0;
      end
    end
    return v;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_rst();
    int n;
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 100) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(cpu_rst_n, 1'b1);
  endtask

  task automatic kp(input logic [7:0] pg, input logic v, input logic [2:0] c,
                    input tkd_keymat_t k);
    logic [31:0] x;
    logic [7:0]  rd;
    logic        oe;
    x    = rnd();
    keys = k;
    i_tkd_cpu_model.access({pg, x[4:0], c}, 1'b1, v, 8'h00, rd, oe);
    if (pg == 8'hC0 && v) begin
      check({oe, rd}, {1'b1, kp_exp(k, c)});
      check(col, c);
    end else begin
      check(oe, 1'b0);
    end
  endtask

  task automatic dw(input logic [7:0] pg, input logic [2:0] dg, input logic [2:0] sg,
                    input logic d);
    logic [31:0] x;
    logic [7:0]  rd;
    logic        oe;
    x = rnd();
    i_tkd_cpu_model.access({pg, 1'b0, dg, 1'b0, sg}, 1'b0, 1'b1, {x[7:1], d}, rd, oe);
    if (pg == 8'hC1 && dg >= 3'h1 && dg <= 3'h6) exp_seg[dg - 3'h1][sg] = ~d;
    check(seg, exp_seg);
  endtask

  always @(negedge clk_sys_i) begin
    if (phi1 === 1'b1 && phi2 === 1'b1) check(2'h3, 2'h1);
  end

  initial begin
    // about fifty accesses of one phase period each, with twofold margin
    #200000;
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rst_i       = 1'b1;
    tsr         = 1'b0;
    key_n       = 1'b1;
    rev_n       = 1'b1;
    ba          = 1'b0;
    keys        = '0;
    exp_seg     = {6{8'hFF}};
    comparisons = 0;
    mismatches  = 0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check({seg, d_oe, cpu_rst_n}, {{6{8'hFF}}, 2'h0});
    rst_i = 1'b0;
    wait_rst();
    // D, E and F held down, every column code plus none
    kp(8'hC0, 1'b1, 3'h3, 18'h00007);
    kp(8'hC0, 1'b1, 3'h5, 18'h00007);
    kp(8'hC0, 1'b1, 3'h6, 18'h00007);
    kp(8'hC0, 1'b1, 3'h7, 18'h3FFFF);
    kp(8'hC0, 1'b1, 3'h3, 18'h00004);
    kp(8'hC0, 1'b1, 3'h3, 18'h00020);
    kp(8'hC0, 1'b1, 3'h5, 18'h00002);
    kp(8'hC0, 1'b0, 3'h3, 18'h3FFFF);
    kp(8'hC2, 1'b1, 3'h3, 18'h3FFFF);
    repeat (16) begin
      r = rnd();
      kp(8'hC0, 1'b1, r[20:18], r[17:0]);
    end
    for (int i = 0; i < 8; i++) dw(8'hC1, i[2:0], 3'h7 - i[2:0], 1'b1);
    dw(8'hC3, 3'h1, 3'h0, 1'b1);
    repeat (16) begin
      r = rnd();
      dw(8'hC1, r[2:0], r[5:3], r[6]);
    end
    for (int i = 0; i < 2; i++) begin
      tsr = (i == 0);
      ba  = (i == 1);
      repeat (6) @(negedge clk_sys_i);
      check({a_oe, rw_oe, dbe_oe, strb_oe, dbe_w, rw_w, strb_w}, 7'h03);
      tsr = 1'b0;
      ba  = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      check({a_oe, rw_oe, dbe_oe, strb_oe, a_buf}, {4'hF, bus.addr});
      check({rw_w, strb_w}, {bus.rw, 1'b1});
    end
    check(dbe, phi2);
    rev_n = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    check(tdo, 1'b0);
    rev_n = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    check(tdo, 1'b1);
    key_n = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    check(cpu_rst_n, 1'b0);
    key_n = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    check(cpu_rst_n, 1'b0);
    wait_rst();
    conclude();
  end
endmodule

`default_nettype wire
